// ---- logic/cmpex_pkg.sv ----
// Constants for the compare, move and pointer instruction executor
// Function
// - Compare-skip-if-less (0110 000a) checks data byte against W unsigned, flags untouched.
// - If the byte is below W the fetched next word is dropped and a no-op runs: 2 cycles.
// - If that dropped word starts a two-word instruction the compare takes 3 cycles.
// - Access bit 0 selects the access bank, access bit 1 uses the bank register.
// - Load-pointer is two words, two cycles; cycle one writes literal bits 11:8 to high byte.
// - Cycle two writes the second word's low eight bits to the low byte, flags untouched.
// - Access bit 0 with extended set on and address up to 95 uses indexed literal offset.
// - Add-to-pointer adds a 6-bit literal to the selected pointer in one cycle, no flags.
// - Selector 11 in the add-to-pointer encoding means add-and-return on pointer two.
// - Add-and-return adds the literal to pointer two and loads PC from the stack top.
// - Add-and-return takes two cycles, the second one a no-op.
// - With the extended-set bit at 0 extended opcodes and indexed addressing are off.
package cmpex_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_INSTR     = 8'h04;
  localparam logic [7:0] REG_NEXT_WORD = 8'h08;
  localparam logic [7:0] REG_WREG      = 8'h0C;
  localparam logic [7:0] REG_BANK      = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_POINTER0  = 8'h18;
  localparam logic [7:0] REG_POINTER1  = 8'h1C;
  localparam logic [7:0] REG_POINTER2  = 8'h20;
  localparam logic [7:0] REG_STACK_TOP = 8'h24;
  localparam logic [7:0] REG_PC        = 8'h28;
  localparam logic [7:0] REG_EXEC_STAT = 8'h2C;
  localparam logic [7:0] REG_EFF_ADDR  = 8'h30;
  localparam logic [7:0] REG_DMEM_BASE = 8'h40;
  localparam logic [7:0] REG_DMEM_MASK = 8'hC0;

  // Widths
  localparam int PTR_W  = 12;
  localparam int PC_W   = 21;
  localparam int BANK_W = 4;
  localparam int DMEM_N = 16;
  localparam int DIDX_W = 4;
  localparam int NPTR   = 3;

  // Field positions
  localparam int CTRL_EXT_BIT  = 0;
  localparam int STAT_Z_BIT    = 0;
  localparam int STAT_N_BIT    = 1;
  localparam int ES_BUSY_BIT   = 0;
  localparam int ES_SKIP_BIT   = 1;
  localparam int ES_CYC_LSB    = 2;
  localparam int EA_INDEX_BIT  = 12;

  // Reset values
  localparam logic [PC_W-1:0]  PC_RESET  = 21'h000000;
  localparam logic [PTR_W-1:0] PTR_RESET = 12'h000;
  localparam logic [15:0]      NOP_WORD  = 16'h0000;

  // Opcode masks and patterns
  localparam logic [15:0] CMP_MASK  = 16'hFE00;
  localparam logic [15:0] CMP_PAT   = 16'h6000;
  localparam logic [15:0] MOV_MASK  = 16'hFC00;
  localparam logic [15:0] MOV_PAT   = 16'h5000;
  localparam logic [15:0] LDP_MASK  = 16'hFFC0;
  localparam logic [15:0] LDP_PAT   = 16'hEE00;
  localparam logic [15:0] ADDP_MASK = 16'hFF00;
  localparam logic [15:0] ADDP_PAT  = 16'hE800;
  localparam logic [15:0] LONG_MASK = 16'hFC00;
  localparam logic [15:0] LONG_PAT  = 16'hEC00;
  localparam logic [15:0] MVFF_MASK = 16'hF000;
  localparam logic [15:0] MVFF_PAT  = 16'hC000;
  localparam logic [1:0]  SEL_RET   = 2'b11;
  localparam logic [1:0]  SEL_PTR2  = 2'b10;

  // Addressing
  localparam logic [7:0]  INDEX_MAX  = 8'h5F;
  localparam logic [11:0] SFR_BASE   = 12'hF00;

  // Program counter steps
  localparam logic [PC_W-1:0] PC_STEP1 = 21'h000002;
  localparam logic [PC_W-1:0] PC_STEP2 = 21'h000004;
  localparam logic [PC_W-1:0] PC_STEP3 = 21'h000006;

  // Quarter phases per instruction cycle
  localparam logic [1:0] Q_LAST = 2'h3;

  // AHB encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {st_idle, st_exec, st_second, st_third} cmpex_state_type;

endpackage : cmpex_pkg

// ---- logic/cmpex_pointer.sv ----
// One indirect pointer register with software, byte and add updates
module cmpex_pointer
  import cmpex_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Software access
  input  wire logic             sw_we,
  input  wire logic [PTR_W-1:0] sw_data,
  // Execution updates
  input  wire logic             hi_we,
  input  wire logic             lo_we,
  input  wire logic [7:0]       lit,
  input  wire logic             add_we,
  input  wire logic [5:0]       add_k,
  // Value
  output logic      [PTR_W-1:0] value
);

  always_ff @(posedge clk)
  begin
    if (rst)
      value <= PTR_RESET;
    else if (hi_we)
      value[PTR_W-1:8] <= lit[3:0];
    else if (lo_we)
      value[7:0] <= lit;
    else if (add_we)
      value <= value + {6'h00, add_k};
    else if (sw_we)
      value <= sw_data;
  end

endmodule : cmpex_pointer

// ---- logic/cmpex_addr.sv ----
// Effective data address for byte instructions
module cmpex_addr
  import cmpex_pkg::*;
(
  // Instruction fields
  input  wire logic              f,
  input  wire logic [7:0]        fa,
  input  wire logic [BANK_W-1:0] bank,
  // Extended set and base pointer
  input  wire logic              ext,
  input  wire logic [PTR_W-1:0]  ptr2,
  // Result
  output logic      [PTR_W-1:0]  addr,
  output logic                   indexed
);

  always_comb
  begin
    indexed = 1'b0;
    if (f)
      addr = {bank, fa};
    else if (ext && (fa <= INDEX_MAX))
    begin
      indexed = 1'b1;
      addr    = ptr2 + {4'h0, fa};
    end
    else if (fa <= INDEX_MAX)
      addr = {4'h0, fa};
    else
      addr = SFR_BASE | {4'h0, fa};
  end

endmodule : cmpex_addr

// ---- logic/cmpex_top.sv ----
// Instruction executor for compare, move and pointer instructions, AHB-Lite slave
//
// The address map and the AHB-Lite slave port were left to the implementer.
module cmpex_top
  import cmpex_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Status
  output logic             exec_busy
);

  // Bus data phase
  logic              ph_we;
  logic [7:0]        ph_addr;

  // Architectural state
  logic              ext_en;
  logic [15:0]       ir;
  logic [15:0]       next_word;
  logic [7:0]        wreg;
  logic [BANK_W-1:0] bank;
  logic              flag_n;
  logic              flag_z;
  logic [PC_W-1:0]   pc;
  logic [PC_W-1:0]   stack_top;
  logic [7:0]        dmem [DMEM_N];
  logic [PTR_W-1:0]  ptr [NPTR];

  // Sequencing
  cmpex_state_type   state;
  logic [1:0]        q_cnt;
  logic [1:0]        cyc_cnt;
  logic [1:0]        last_cyc;
  logic              last_skip;
  logic              skip_long;
  logic [PTR_W:0]    eff_seen;

  // Decode
  logic              busy;
  logic              q_last;
  logic              ex_fire;
  logic              sec_fire;
  logic              start;
  logic              is_cmp;
  logic              is_mov;
  logic              is_ldp;
  logic              is_addp;
  logic              is_ret;
  logic [1:0]        sel_ldp;
  logic [1:0]        sel_add;
  logic [PTR_W-1:0]  eff_addr;
  logic              eff_indexed;
  logic [7:0]        mem_val;
  logic              less;
  logic              next_long;
  logic [31:0]       rd_val;
  logic [7:0]        rd_addr;

  assign busy     = (state != st_idle);
  assign q_last   = busy && (q_cnt == Q_LAST);
  assign ex_fire  = q_last && (state == st_exec);
  assign sec_fire = q_last && (state == st_second);
  assign start    = ph_we && (ph_addr == REG_INSTR) && !busy;

  function automatic logic sw_we(input logic [7:0] a);
    sw_we = ph_we && !busy && (ph_addr == a);
  endfunction : sw_we

  // Opcode decode
  always_comb
  begin
    is_cmp    = (ir & CMP_MASK) == CMP_PAT;
    is_mov    = (ir & MOV_MASK) == MOV_PAT;
    is_ldp    = (ir & LDP_MASK) == LDP_PAT;
    sel_ldp   = ir[5:4];
    sel_add   = ir[7:6];
    is_addp   = ext_en && ((ir & ADDP_MASK) == ADDP_PAT) && (sel_add != SEL_RET);
    is_ret    = ext_en && ((ir & ADDP_MASK) == ADDP_PAT) && (sel_add == SEL_RET);
    next_long = ((next_word & LONG_MASK) == LONG_PAT) ||
                ((next_word & MVFF_MASK) == MVFF_PAT);
  end

  cmpex_addr u_addr
  (
    .f       (ir[8]),
    .fa      (ir[7:0]),
    .bank    (bank),
    .ext     (ext_en),
    .ptr2    (ptr[2]),
    .addr    (eff_addr),
    .indexed (eff_indexed)
  );

  assign mem_val = dmem[eff_addr[DIDX_W-1:0]];
  assign less    = mem_val < wreg;

  // Pointer registers
  genvar gi;
  generate
    for (gi = 0; gi < NPTR; gi++)
    begin : g_ptr
      cmpex_pointer u_ptr
      (
        .clk     (clk),
        .rst     (rst),
        .sw_we   (sw_we(REG_POINTER0 + 8'(4 * gi))),
        .sw_data (hwdata[PTR_W-1:0]),
        .hi_we   (ex_fire && is_ldp && (sel_ldp == 2'(gi))),
        .lo_we   (sec_fire && is_ldp && (sel_ldp == 2'(gi))),
        .lit     (ex_fire ? ir[7:0] : next_word[7:0]),
        .add_we  (ex_fire && ((is_addp && (sel_add == 2'(gi))) ||
                              (is_ret && (SEL_PTR2 == 2'(gi))))),
        .add_k   (ir[5:0]),
        .value   (ptr[gi])
      );
    end
  endgenerate

  // AHB address phase capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ph_we   <= 1'b0;
      ph_addr <= 8'h00;
    end
    else if (hready)
    begin
      ph_we   <= hsel && htrans[1] && hwrite && (hsize == HSIZE_WORD);
      ph_addr <= haddr[7:0];
    end
  end

  // Read data registered at the address phase
  always_comb
  begin
    rd_addr = haddr[7:0];
    rd_val  = 32'h0000_0000;
    if ((rd_addr & REG_DMEM_MASK) == REG_DMEM_BASE)
      rd_val = {24'h000000, dmem[rd_addr[DIDX_W+1:2]]};
    else
      case (rd_addr)
        REG_CTRL:      rd_val[CTRL_EXT_BIT] = ext_en;
        REG_INSTR:     rd_val[15:0] = ir;
        REG_NEXT_WORD: rd_val[15:0] = next_word;
        REG_WREG:      rd_val[7:0] = wreg;
        REG_BANK:      rd_val[BANK_W-1:0] = bank;
        REG_STATUS:
        begin
          rd_val[STAT_N_BIT] = flag_n;
          rd_val[STAT_Z_BIT] = flag_z;
        end
        REG_POINTER0:  rd_val[PTR_W-1:0] = ptr[0];
        REG_POINTER1:  rd_val[PTR_W-1:0] = ptr[1];
        REG_POINTER2:  rd_val[PTR_W-1:0] = ptr[2];
        REG_STACK_TOP: rd_val[PC_W-1:0] = stack_top;
        REG_PC:        rd_val[PC_W-1:0] = pc;
        REG_EXEC_STAT:
        begin
          rd_val[ES_BUSY_BIT]            = busy;
          rd_val[ES_SKIP_BIT]            = last_skip;
          rd_val[ES_CYC_LSB+1:ES_CYC_LSB] = last_cyc;
        end
        REG_EFF_ADDR:  rd_val[PTR_W:0] = eff_seen;
        default:       rd_val = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      exec_busy <= 1'b0;
    end
    else
    begin
      if (hsel && htrans[1] && hready && !hwrite)
        hrdata <= rd_val;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      exec_busy <= start || (busy && !(q_last && (state == st_third ||
                   (state == st_second && !skip_long) ||
                   (state == st_exec && !(is_ldp || is_ret || (is_cmp && less))))));
    end
  end

  // Configuration and instruction words
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_en    <= 1'b0;
      ir        <= NOP_WORD;
      next_word <= NOP_WORD;
      bank      <= '0;
      stack_top <= PC_RESET;
    end
    else
    begin
      if (sw_we(REG_CTRL))
        ext_en <= hwdata[CTRL_EXT_BIT];
      if (start)
        ir <= hwdata[15:0];
      if (sw_we(REG_NEXT_WORD))
        next_word <= hwdata[15:0];
      if (sw_we(REG_BANK))
        bank <= hwdata[BANK_W-1:0];
      if (sw_we(REG_STACK_TOP))
        stack_top <= hwdata[PC_W-1:0];
    end
  end

  // Quarter phase divider
  always_ff @(posedge clk)
  begin
    if (rst || start || !busy)
      q_cnt <= 2'h0;
    else
      q_cnt <= q_cnt + 2'h1;
  end

  // Instruction cycle sequencer
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state     <= st_idle;
      skip_long <= 1'b0;
    end
    else if (start)
      state <= st_exec;
    else if (q_last)
      case (state)
        st_exec:
        begin
          skip_long <= is_cmp && less && next_long;
          if ((is_cmp && less) || is_ldp || is_ret)
            state <= st_second;
          else
            state <= st_idle;
        end
        st_second:
          state <= skip_long ? st_third : st_idle;
        st_third:
          state <= st_idle;
        default:
          state <= st_idle;
      endcase
  end

  // Cycle accounting
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cyc_cnt   <= 2'h0;
      last_cyc  <= 2'h0;
      last_skip <= 1'b0;
      eff_seen  <= '0;
    end
    else
    begin
      if (start)
        cyc_cnt <= 2'h0;
      else if (q_last)
        cyc_cnt <= cyc_cnt + 2'h1;
      if (q_last && ((state == st_third) || (state == st_second && !skip_long) ||
          (state == st_exec && !(is_ldp || is_ret || (is_cmp && less)))))
        last_cyc <= cyc_cnt + 2'h1;
      if (ex_fire)
        last_skip <= is_cmp && less;
      if (ex_fire && (is_cmp || is_mov))
        eff_seen <= {eff_indexed, eff_addr};
    end
  end

  // Program counter
  always_ff @(posedge clk)
  begin
    if (rst)
      pc <= PC_RESET;
    else if (ex_fire)
    begin
      if (is_ret)
        pc <= stack_top;
      else if (is_cmp && less)
        pc <= pc + (next_long ? PC_STEP3 : PC_STEP2);
      else if (is_ldp)
        pc <= pc + PC_STEP2;
      else
        pc <= pc + PC_STEP1;
    end
    else if (sw_we(REG_PC))
      pc <= hwdata[PC_W-1:0];
  end

  // Working register and flags; compare leaves flags alone
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wreg   <= 8'h00;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
    end
    else if (ex_fire && is_mov)
    begin
      if (!ir[9])
        wreg <= mem_val;
      flag_n <= mem_val[7];
      flag_z <= (mem_val == 8'h00);
    end
    else
    begin
      if (sw_we(REG_WREG))
        wreg <= hwdata[7:0];
      if (sw_we(REG_STATUS))
      begin
        flag_n <= hwdata[STAT_N_BIT];
        flag_z <= hwdata[STAT_Z_BIT];
      end
    end
  end

  // Data memory window, low address bits select the byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < DMEM_N; i++)
        dmem[i] <= 8'h00;
    end
    else if (ex_fire && is_mov && ir[9])
      dmem[eff_addr[DIDX_W-1:0]] <= mem_val;
    else if (ph_we && !busy && ((ph_addr & REG_DMEM_MASK) == REG_DMEM_BASE))
      dmem[ph_addr[DIDX_W+1:2]] <= hwdata[7:0];
  end

endmodule : cmpex_top

// ---- verification/cmpex_top_sva.sv ----
// Concurrent checks on the executor's bus and busy ports
module cmpex_top_sva
  import cmpex_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Status
  input wire logic        exec_busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [4:0] busy_len;
  logic       rd_ap;
  logic       go_ap;
  assign rd_ap = hsel && htrans[1] && hready && !hwrite;
  assign go_ap = hsel && htrans[1] && hready && hwrite && hsize == HSIZE_WORD
                 && haddr[7:0] == REG_INSTR;
  // Length of the current busy run
  always_ff @(posedge clk)
  begin
    if (rst || !exec_busy)
      busy_len <= 5'h00;
    else
      busy_len <= busy_len + 5'h01;
  end
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_reset_quiet: assert property (disable iff (1'b0) rst |=> !exec_busy && hrdata == 32'h0)
    else $error("outputs not cleared by reset");
  a_busy_min: assert property ($rose(exec_busy) |-> exec_busy [*4])
    else $error("busy shorter than one cycle");
  a_busy_bound: assert property ($rose(exec_busy) |-> ##[4:12] !exec_busy)
    else $error("busy longer than three cycles");
  a_busy_len: assert property ($fell(exec_busy) |-> busy_len inside {5'h04, 5'h08, 5'h0C})
    else $error("busy not whole instruction cycles");
  a_start_busy: assert property (go_ap && !exec_busy ##1 !exec_busy |-> ##2 exec_busy)
    else $error("instruction write did not start execution");
  // Address phase, data phase commit, then busy is first seen high
  a_busy_cause: assert property ($rose(exec_busy) |-> $past(go_ap, 2))
    else $error("busy without instruction write");
  a_read_hold: assert property (!$stable(hrdata) |-> $past(rd_ap) || $past(rst))
    else $error("read data changed without read");
  c_one_cycle: cover property ($fell(exec_busy) && busy_len == 5'h04);
  c_two_cycle: cover property ($fell(exec_busy) && busy_len == 5'h08);
  c_three_cycle: cover property ($fell(exec_busy) && busy_len == 5'h0C);
endmodule : cmpex_top_sva

bind cmpex_top cmpex_top_sva cmpex_top_sva_i (.clk(clk), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .exec_busy(exec_busy));

// ---- verification/cmpex_host_model.sv ----
// Bus master model issuing single word transfers to the executor
module cmpex_host_model
  import cmpex_pkg::*;
(
  // Clock
  input  wire logic        clk,
  // Bus
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hwdata <= ~hwdata;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : xfer
endmodule : cmpex_host_model

// ---- verification/cmpex_top_tb.sv ----
// Self-checking bench for the instruction executor
module cmpex_top_tb
  import cmpex_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic ext; logic [15:0] op; logic [15:0] nw; int cyc;
    logic [20:0] pc; logic [7:0] ra; logic [31:0] rv;
  } cmpex_row_type;
  // Ordinary cases: mode, opcode, following word, cycles, PC, register, value
  cmpex_row_type rows [22] = '{
    '{1, 16'h6105, 16'h0000, 2, 21'h104, REG_EXEC_STAT, 32'hA},
    '{1, 16'h6105, 16'hEE00, 3, 21'h106, REG_EXEC_STAT, 32'hE},
    '{1, 16'h6105, 16'hC000, 3, 21'h106, REG_EFF_ADDR, 32'h305},
    '{1, 16'h6106, 16'hEE00, 1, 21'h102, REG_EXEC_STAT, 32'h4},
    '{1, 16'h6107, 16'h0000, 1, 21'h102, REG_EXEC_STAT, 32'h4},
    '{1, 16'h5106, 16'h0000, 1, 21'h102, REG_WREG, 32'h40},
    '{1, 16'h5308, 16'h0000, 1, 21'h102, REG_STATUS, 32'h1},
    '{1, 16'h5109, 16'h0000, 1, 21'h102, REG_STATUS, 32'h2},
    '{1, 16'h6106, 16'h0000, 2, 21'h104, REG_STATUS, 32'h2},
    '{1, 16'hEE13, 16'h00AB, 2, 21'h104, REG_POINTER1, 32'h3AB},
    '{1, 16'hEE23, 16'hF0FF, 2, 21'h104, REG_POINTER2, 32'h3FF},
    '{1, 16'hE83F, 16'h0000, 1, 21'h102, REG_POINTER0, 32'h3F},
    '{1, 16'hE8A3, 16'h0000, 1, 21'h102, REG_POINTER2, 32'h422},
    '{1, 16'hEE1F, 16'h00FF, 2, 21'h104, REG_POINTER1, 32'hFFF},
    '{1, 16'hE841, 16'h0000, 1, 21'h102, REG_POINTER1, 32'h0},
    '{1, 16'hE8C1, 16'h0000, 2, 21'h1234, REG_POINTER2, 32'h423},
    '{1, 16'h6005, 16'h0000, 2, 21'h104, REG_EFF_ADDR, 32'h1428},
    '{1, 16'h605F, 16'h0000, 2, 21'h104, REG_EFF_ADDR, 32'h1482},
    '{1, 16'h6060, 16'h0000, 2, 21'h104, REG_EFF_ADDR, 32'hF60},
    '{0, 16'h6005, 16'h0000, 2, 21'h104, REG_EFF_ADDR, 32'h5},
    '{0, 16'hE83F, 16'h0000, 1, 21'h102, REG_POINTER0, 32'h3F},
    '{0, 16'hE8C1, 16'h0000, 1, 21'h102, REG_POINTER2, 32'h423}
  };
  logic [7:0]  dm [10] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h20, 8'h40, 8'h30, 8'h0, 8'h80};
  logic [7:0]  zero_regs [7] = '{REG_CTRL, REG_WREG, REG_PC, REG_POINTER0, REG_POINTER2,
                                 REG_EXEC_STAT, 8'h3C};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        exec_busy;
  logic [31:0] q;
  int          n;
  int          fails = 0;
  int          samples_checked = 0;
  always #25 clk = ~clk;
  cmpex_top cmpex_top_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .exec_busy(exec_busy));
  cmpex_host_model cmpex_host_model_i (.clk(clk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    cmpex_host_model_i.xfer(1'b1, a, d, unused);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    cmpex_host_model_i.xfer(1'b0, a, 32'h0, d);
  endtask : rd
  // Busy run length in clocks
  task automatic count_busy(output int c);
    int k;
    k = 0;
    c = 0;
    while (exec_busy !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    while (exec_busy === 1'b1 && c < 40)
    begin
      @(posedge clk);
      c++;
    end
  endtask : count_busy
  task automatic test_done;
    $display("Checks made %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  initial
  begin
    repeat (8000) @(posedge clk);
    fails++;
    test_done();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wr(REG_WREG, 32'h30);
    wr(REG_BANK, 32'h3);
    wr(REG_STACK_TOP, 32'h1234);
    foreach (dm[i]) wr(REG_DMEM_BASE + 8'(4 * i), {24'h0, dm[i]});
    foreach (rows[i])
    begin
      wr(REG_CTRL, {31'h0, rows[i].ext});
      wr(REG_PC, 32'h100);
      wr(REG_NEXT_WORD, {16'h0, rows[i].nw});
      wr(REG_INSTR, {16'h0, rows[i].op});
      count_busy(n);
      chk($sformatf("row %0d clocks", i), n, 4 * rows[i].cyc);
      rd(REG_PC, q);
      chk($sformatf("row %0d pc", i), q, {11'h0, rows[i].pc});
      rd(rows[i].ra, q);
      chk($sformatf("row %0d reg", i), q, rows[i].rv);
    end
    // Writes landing while a skip is still running
    wr(REG_CTRL, 32'h1);
    wr(REG_NEXT_WORD, 32'h0);
    wr(REG_INSTR, 32'h6105);
    wr(REG_WREG, 32'h11);
    wr(REG_INSTR, 32'hE801);
    count_busy(n);
    rd(REG_WREG, q);
    chk("wreg after busy write", q, 32'h80);
    rd(REG_POINTER0, q);
    chk("pointer0 after busy write", q, 32'h3F);
    rd(REG_EXEC_STAT, q);
    chk("skip status", q, 32'hA);
    // Reset once the skip has finished, then reset values and an unmapped place
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    chk("busy after reset", {31'h0, exec_busy}, 32'h0);
    wr(8'h3C, 32'hFFFFFFFF);
    foreach (zero_regs[i])
    begin
      rd(zero_regs[i], q);
      chk($sformatf("reset value %h", zero_regs[i]), q, 32'h0);
    end
    test_done();
  end
endmodule : cmpex_top_tb
